// ---- src/rsp_pkg.sv ----
// constants for the return stack pointer unit
// assumes a 32-bit ahb-lite slave, one word per register
package rsp_pkg;
    localparam int          IDX_W        = 5;
    localparam int          ADDR_W       = 21;
    localparam int          DEPTH        = 31;
    localparam logic [4:0]  IDX_MAX      = 5'h1F;
    localparam logic [4:0]  IDX_ZERO     = 5'h00;
    localparam logic [20:0] PC_STEP      = 21'h000002;
    // register byte offsets
    localparam logic [7:0]  OFS_TOP_OF_STACK_UPPER     = 8'h00;
    localparam logic [7:0]  OFS_TOP_OF_STACK_HIGH     = 8'h04;
    localparam logic [7:0]  OFS_TOP_OF_STACK_LOW     = 8'h08;
    localparam logic [7:0]  OFS_INDEX    = 8'h0C;
    localparam logic [7:0]  OFS_CONFIG   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h18;
    // index register fields
    localparam int          BIT_FULL     = 7;
    localparam int          BIT_UNF      = 6;
    localparam logic [7:0]  INDEX_RESET  = 8'h00;
    // config: bit 0 overflow_reset_enable, set by default
    localparam logic        CFG_RESET    = 1'b1;
    // irq status bits
    localparam int          IRQ_FULL     = 0;
    localparam int          IRQ_UNF      = 1;
    localparam int          IRQ_W        = 2;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
endpackage

// ---- src/rsp_unit.sv ----
// return address stack with index, full and underflow flags
// assumes one ahb-lite master, core push/pop pulses on clk
//
// What this block does
// - stack index ranges from zero to thirty-one.
// - push increments the index, pop decrements it.
// - core reset (rst_b) clears the stack index to zero; power-on reset alone does not.
// - software reads and writes the stack index via its register.
// - full flag sets after thirty-one pushes with no pops.
// - full flag cleared only by software write or power-on reset.
// - overflow reset enabled: 31st push stores pc+2, sets full, resets.
// - after overflow reset, full stays set and index is zero.
// - overflow reset disabled: 31st push sets full, index goes to 31.
// - further pushes ignored, entry unchanged, index holds at 31.
// - empty pop returns zero, sets underflow, index stays zero.
// - underflow holds until software clear or power-on reset.
// - index register: full bit 7, underflow bit 6, index bits 4:0.
// - 31x21 memory; push increments then writes, pop reads then decrements.
// - push on call, relative call, interrupt; pop on returns.
// - three top-of-stack registers access the entry at the index.
`timescale 1ns/10ps
module rsp_unit (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        por_b,
    input  wire logic        call_instr,
    input  wire logic        relative_call_instr,
    input  wire logic        irq_ack,
    input  wire logic        return_instr,
    input  wire logic        return_with_literal_instr,
    input  wire logic        return_from_interrupt_instr,
    input  wire logic [20:0] program_counter,
    output logic      [20:0] return_address,
    output logic             return_valid,
    output logic             overflow_reset_req,
    output logic             irq,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    logic [20:0] mem [1:rsp_pkg::DEPTH];
    logic [4:0]  index_reg, index_next;
    logic        full_reg, full_next, unf_reg, unf_next;
    logic        cfg_reg, cfg_next;
    logic [1:0]  stat_reg, stat_next, mask_reg, mask_next;
    logic [20:0] ret_reg, ret_next;
    logic        rv_reg, rv_next, ovr_reg, ovr_next, irq_next;
    logic        wph_reg, wph_next;
    logic [7:0]  wad_reg, wad_next;
    logic [31:0] rd_reg, rd_next;
    logic        push, pop, mem_we;
    logic [4:0]  mem_wa;
    logic [20:0] mem_wd, tos;
    logic        sw_wr, addr_ph;
    logic [1:0]  ev;

    assign push = call_instr | relative_call_instr | irq_ack;
    assign pop  = return_instr | return_with_literal_instr
                | return_from_interrupt_instr;
    assign tos  = (index_reg == rsp_pkg::IDX_ZERO) ? 21'h000000
                : mem[index_reg];
    assign sw_wr   = wph_reg;
    assign addr_ph = hsel & hready & htrans[1];

    always_comb begin
        index_next = index_reg;
        full_next  = full_reg;
        unf_next   = unf_reg;
        cfg_next   = cfg_reg;
        mask_next  = mask_reg;
        ret_next   = ret_reg;
        rv_next    = 1'b0;
        ovr_next   = 1'b0;
        mem_we     = 1'b0;
        mem_wa     = index_reg;
        mem_wd     = program_counter;
        ev         = 2'h0;
        wph_next   = addr_ph & hwrite;
        wad_next   = haddr[7:0];
        rd_next    = 32'h00000000;
        if (push) begin
            if (index_reg == rsp_pkg::IDX_MAX) begin
                ev[rsp_pkg::IRQ_FULL] = 1'b1;
            end else if (index_reg == rsp_pkg::IDX_MAX - 5'h01) begin
                full_next = 1'b1;
                ev[rsp_pkg::IRQ_FULL] = 1'b1;
                mem_we = 1'b1;
                mem_wa = rsp_pkg::IDX_MAX;
                if (cfg_reg) begin
                    mem_wd     = program_counter + rsp_pkg::PC_STEP;
                    ovr_next   = 1'b1;
                    index_next = rsp_pkg::IDX_ZERO;
                end else begin
                    index_next = rsp_pkg::IDX_MAX;
                end
            end else begin
                index_next = index_reg + 5'h01;
                mem_we = 1'b1;
                mem_wa = index_reg + 5'h01;
            end
        end else if (pop) begin
            rv_next  = 1'b1;
            ret_next = tos;
            if (index_reg == rsp_pkg::IDX_ZERO) begin
                unf_next = 1'b1;
                ev[rsp_pkg::IRQ_UNF] = 1'b1;
            end else begin
                index_next = index_reg - 5'h01;
            end
        end
        if (sw_wr) begin
            case (wad_reg)
                rsp_pkg::OFS_INDEX: begin
                    index_next = hwdata[4:0];
                    // hardware set wins over the software clear
                    full_next = hwdata[rsp_pkg::BIT_FULL] | full_next;
                    unf_next  = hwdata[rsp_pkg::BIT_UNF] | unf_next;
                    if (!hwdata[rsp_pkg::BIT_FULL] && !(push && full_next
                        && !full_reg))
                        full_next = 1'b0;
                    if (!hwdata[rsp_pkg::BIT_UNF] && !ev[rsp_pkg::IRQ_UNF])
                        unf_next = 1'b0;
                end
                rsp_pkg::OFS_TOP_OF_STACK_UPPER, rsp_pkg::OFS_TOP_OF_STACK_HIGH, rsp_pkg::OFS_TOP_OF_STACK_LOW:
                begin
                    if (index_reg != rsp_pkg::IDX_ZERO && !mem_we) begin
                        mem_we = 1'b1;
                        mem_wa = index_reg;
                        mem_wd = tos;
                        if (wad_reg == rsp_pkg::OFS_TOP_OF_STACK_UPPER)
                            mem_wd[20:16] = hwdata[4:0];
                        else if (wad_reg == rsp_pkg::OFS_TOP_OF_STACK_HIGH)
                            mem_wd[15:8] = hwdata[7:0];
                        else
                            mem_wd[7:0] = hwdata[7:0];
                    end
                end
                rsp_pkg::OFS_CONFIG:   cfg_next  = hwdata[0];
                rsp_pkg::OFS_IRQ_MASK: mask_next = hwdata[1:0];
                default: ;
            endcase
        end
        stat_next = stat_reg;
        if (sw_wr && wad_reg == rsp_pkg::OFS_IRQ_STAT)
            stat_next = stat_reg & ~hwdata[1:0];
        stat_next = stat_next | ev;
        irq_next  = |(stat_next & mask_next);
        if (addr_ph && !hwrite) begin
            case (haddr[7:0])
                rsp_pkg::OFS_TOP_OF_STACK_UPPER:     rd_next = {27'h0, tos[20:16]};
                rsp_pkg::OFS_TOP_OF_STACK_HIGH:     rd_next = {24'h0, tos[15:8]};
                rsp_pkg::OFS_TOP_OF_STACK_LOW:     rd_next = {24'h0, tos[7:0]};
                rsp_pkg::OFS_INDEX:
                    rd_next = {24'h0, full_reg, unf_reg, 1'b0,
                               index_reg};
                rsp_pkg::OFS_CONFIG:   rd_next = {31'h0, cfg_reg};
                rsp_pkg::OFS_IRQ_STAT: rd_next = {30'h0, stat_reg};
                rsp_pkg::OFS_IRQ_MASK: rd_next = {30'h0, mask_reg};
                default:               rd_next = 32'h00000000;
            endcase
        end
    end

    // flags live in the power-on domain so core resets keep them
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            full_reg <= 1'b0;
            unf_reg  <= 1'b0;
        end else begin
            full_reg <= full_next;
            unf_reg  <= unf_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            index_reg <= rsp_pkg::IDX_ZERO;
            cfg_reg   <= rsp_pkg::CFG_RESET;
            stat_reg  <= 2'h0;
            mask_reg  <= 2'h0;
            ret_reg   <= 21'h000000;
            rv_reg    <= 1'b0;
            ovr_reg   <= 1'b0;
            irq       <= 1'b0;
            wph_reg   <= 1'b0;
            wad_reg   <= 8'h00;
            rd_reg    <= 32'h00000000;
        end else begin
            index_reg <= index_next;
            cfg_reg   <= cfg_next;
            stat_reg  <= stat_next;
            mask_reg  <= mask_next;
            ret_reg   <= ret_next;
            rv_reg    <= rv_next;
            ovr_reg   <= ovr_next;
            irq       <= irq_next;
            wph_reg   <= wph_next;
            wad_reg   <= wad_next;
            rd_reg    <= rd_next;
        end
    end

    // stack ram has no reset, like a real macro
    always_ff @(posedge clk) begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    assign return_address     = ret_reg;
    assign return_valid       = rv_reg;
    assign overflow_reset_req = ovr_reg;
    assign hrdata             = rd_reg;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;

    a_index_range: assert property (@(posedge clk) disable iff (!rst_b)
        index_reg <= rsp_pkg::IDX_MAX) else $error("index out of range");
    a_push_incr: assert property (@(posedge clk) disable iff (!rst_b)
        push && !sw_wr && index_reg < 5'h1E |=> index_reg ==
        $past(index_reg) + 5'h01) else $error("push did not increment");
    a_pop_decr: assert property (@(posedge clk) disable iff (!rst_b)
        pop && !push && !sw_wr && index_reg != 5'h00 |=> index_reg ==
        $past(index_reg) - 5'h01) else $error("pop did not decrement");
    a_full_set: assert property (@(posedge clk) disable iff (!rst_b)
        push && index_reg == 5'h1E |=> full_reg)
        else $error("full not set on 31st push");
    a_ovr_reset: assert property (@(posedge clk) disable iff (!rst_b)
        push && cfg_reg && index_reg == 5'h1E && !sw_wr |=>
        overflow_reset_req && index_reg == 5'h00)
        else $error("overflow reset missing");
    a_hold_max: assert property (@(posedge clk) disable iff (!rst_b)
        push && index_reg == 5'h1F && !sw_wr |=> index_reg == 5'h1F)
        else $error("index left 31");
    a_underflow: assert property (@(posedge clk) disable iff (!rst_b)
        pop && !push && index_reg == 5'h00 && !sw_wr |=> unf_reg &&
        return_address == 21'h0 && return_valid && index_reg == 5'h00)
        else $error("underflow handling wrong");
    a_unf_sticky: assert property (@(posedge clk) disable iff (!por_b)
        unf_reg && !sw_wr |=> unf_reg)
        else $error("underflow dropped");
    a_full_sticky: assert property (@(posedge clk) disable iff (!por_b)
        full_reg && !sw_wr |=> full_reg)
        else $error("full dropped");

    // ram checks below look at the entry the core just wrote, popped or left unchanged
    a_push_write: assert property (@(posedge clk) disable iff (!rst_b)
        push && !sw_wr && index_reg < 5'h1E
        |=> mem[index_reg] == $past(program_counter))
        else $error("push entry not written");

    a_pop_data: assert property (@(posedge clk) disable iff (!rst_b)
        pop && !push && index_reg != 5'h00
        |=> return_valid && return_address == $past(tos))
        else $error("pop returned wrong entry");

    a_ovr_entry: assert property (@(posedge clk) disable iff (!rst_b)
        push && cfg_reg && index_reg == 5'h1E
        |=> mem[31] == $past(program_counter) + rsp_pkg::PC_STEP)
        else $error("overflow entry not pc plus two");

    a_noovr_index: assert property (@(posedge clk) disable iff (!rst_b)
        push && !cfg_reg && index_reg == 5'h1E && !sw_wr
        |=> index_reg == 5'h1F && !overflow_reset_req)
        else $error("full without reset wrong");

    a_hold_entry: assert property (@(posedge clk) disable iff (!rst_b)
        push && index_reg == 5'h1F && !sw_wr
        |=> mem[31] == $past(mem[31]))
        else $error("entry 31 overwritten");

    // the reset request must come with the full flag still set
    a_ovr_flags: assert property (@(posedge clk) disable iff (!rst_b)
        overflow_reset_req
        |-> full_reg)
        else $error("overflow request without full");

    a_tos_zero_rd: assert property (@(posedge clk) disable iff (!rst_b)
        addr_ph && !hwrite && haddr[7:0] == rsp_pkg::OFS_TOP_OF_STACK_LOW
        && index_reg == 5'h00
        |=> hrdata == 32'h00000000)
        else $error("top of stack at index zero not zero");

    a_stat_unf: assert property (@(posedge clk) disable iff (!rst_b)
        pop && !push && index_reg == 5'h00
        |=> stat_reg[rsp_pkg::IRQ_UNF])
        else $error("underflow event not recorded");

    a_sw_full_clr: assert property (@(posedge clk) disable iff (!rst_b)
        sw_wr && wad_reg == rsp_pkg::OFS_INDEX
        && !hwdata[rsp_pkg::BIT_FULL] && !push
        |=> !full_reg)
        else $error("software clear of full lost");

    a_sw_index_wr: assert property (@(posedge clk) disable iff (!rst_b)
        sw_wr && wad_reg == rsp_pkg::OFS_INDEX
        |=> index_reg == $past(hwdata[4:0]))
        else $error("software index write lost");

    // a core reset alone must bring the index back to zero
    a_core_reset: assert property (@(posedge clk) disable iff (!por_b)
        $rose(rst_b)
        |-> index_reg == 5'h00)
        else $error("index not zero after reset");
endmodule // rsp_unit

// ---- test/rsp_core_model.sv ----
// core side model: sequencer issuing push and pop pulses plus the pc
// assumes the unit samples each pulse at the next rising edge of clk
`timescale 1ns/10ps
module rsp_core_model (
    input  wire logic        clk,
    output logic             call_instr,
    output logic             relative_call_instr,
    output logic             irq_ack,
    output logic             return_instr,
    output logic             return_with_literal_instr,
    output logic             return_from_interrupt_instr,
    output logic      [20:0] program_counter
);
    initial begin
        {call_instr, relative_call_instr, irq_ack} = 3'h0;
        return_instr = 1'b0;
        return_with_literal_instr = 1'b0;
        return_from_interrupt_instr = 1'b0;
        program_counter = 21'h000000;
    end
    // kind 0 call, 1 relative call, 2 interrupt entry
    task automatic push(input int kind, input logic [20:0] pc);
        @(posedge clk);
        program_counter <= pc;
        call_instr <= (kind == 0);
        relative_call_instr <= (kind == 1);
        irq_ack <= (kind == 2);
        @(posedge clk);
        {call_instr, relative_call_instr, irq_ack} <= 3'h0;
        // pc bus moves on, so a late sample never sees the pushed value
        program_counter <= ~pc;
    endtask
    // kind 0 return, 1 return with literal, 2 return from interrupt
    task automatic pop(input int kind);
        @(posedge clk);
        return_instr <= (kind == 0);
        return_with_literal_instr <= (kind == 1);
        return_from_interrupt_instr <= (kind == 2);
        @(posedge clk);
        return_instr <= 1'b0;
        return_with_literal_instr <= 1'b0;
        return_from_interrupt_instr <= 1'b0;
    endtask
endmodule // rsp_core_model

// ---- test/rsp_unit_tb.sv ----
// self-checking bench: ahb-lite register master plus core model
// assumes zero wait state slave and registered core outputs
`timescale 1ns/10ps
module rsp_unit_tb;
    logic        clk, rst_b, por_b, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [20:0] return_address, program_counter;
    logic        return_valid, overflow_reset_req, irq, hreadyout, hresp;
    logic        ci, rci, ia, ri, rli, rfi;
    int          miscompares = 0, num_checks = 0, cycles = 0;
    rsp_core_model rsp_core_model_inst (.clk(clk), .call_instr(ci),
        .relative_call_instr(rci), .irq_ack(ia), .return_instr(ri),
        .return_with_literal_instr(rli), .return_from_interrupt_instr(rfi),
        .program_counter(program_counter));
    rsp_unit rsp_unit_inst (.clk(clk), .rst_b(rst_b), .por_b(por_b),
        .call_instr(ci), .relative_call_instr(rci), .irq_ack(ia),
        .return_instr(ri), .return_with_literal_instr(rli),
        .return_from_interrupt_instr(rfi), .program_counter(program_counter),
        .return_address(return_address), .return_valid(return_valid),
        .overflow_reset_req(overflow_reset_req), .irq(irq), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        logic rdy;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= rsp_pkg::HTRANS_NSEQ;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        // read data settles mid-cycle; the closing edge reloads hrdata
        do begin
            @(negedge clk);
            d = hrdata;
            rdy = hreadyout;
            @(posedge clk);
        end while (rdy !== 1'b1);
        chk({31'h00000000, hresp}, 32'h00000000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(d, e);
    endtask
    task automatic core_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task automatic t_reset_values();
        rd(rsp_pkg::OFS_INDEX, 32'h00000000);
        rd(rsp_pkg::OFS_CONFIG, 32'h00000001);
        rd(rsp_pkg::OFS_TOP_OF_STACK_UPPER, 32'h00000000);
        rd(8'h1C, 32'h00000000);
    endtask
    task automatic t_push_pop();
        logic [20:0] pcs [3] = '{21'h1ABCDE, 21'h0F0123, 21'h155AA4};
        for (int k = 0; k < 3; k++) rsp_core_model_inst.push(k, pcs[k]);
        rd(rsp_pkg::OFS_INDEX, 32'h00000003);
        rd(rsp_pkg::OFS_TOP_OF_STACK_UPPER, 32'h00000015);
        rd(rsp_pkg::OFS_TOP_OF_STACK_HIGH, 32'h0000005A);
        rd(rsp_pkg::OFS_TOP_OF_STACK_LOW, 32'h000000A4);
        for (int k = 0; k < 3; k++) begin
            rsp_core_model_inst.pop(k);
            #1 chk({return_valid, return_address}, {1'b1, pcs[2-k]});
        end
        rd(rsp_pkg::OFS_INDEX, 32'h00000000);
    endtask
    task automatic t_underflow();
        bus(1'b1, rsp_pkg::OFS_IRQ_MASK, 32'h00000002);
        rsp_core_model_inst.pop(0);
        #1 chk({return_valid, return_address}, {1'b1, 21'h000000});
        rd(rsp_pkg::OFS_INDEX, 32'h00000040);
        chk(irq, 1'b1);
        bus(1'b1, rsp_pkg::OFS_IRQ_MASK, 32'h00000000);
        rd(rsp_pkg::OFS_IRQ_STAT, 32'h00000002);
        chk(irq, 1'b0);
        bus(1'b1, rsp_pkg::OFS_IRQ_MASK, 32'h00000002);
        bus(1'b1, rsp_pkg::OFS_IRQ_STAT, 32'h00000002);
        rd(rsp_pkg::OFS_IRQ_STAT, 32'h00000000);
        chk(irq, 1'b0);
        core_reset();
        rd(rsp_pkg::OFS_INDEX, 32'h00000040);
        bus(1'b1, rsp_pkg::OFS_INDEX, 32'h00000000);
        rd(rsp_pkg::OFS_INDEX, 32'h00000000);
    endtask
    task automatic t_full_hold();
        bus(1'b1, rsp_pkg::OFS_CONFIG, 32'h00000000);
        for (int i = 1; i <= 31; i++) rsp_core_model_inst.push(i % 3, 21'(i*2));
        rd(rsp_pkg::OFS_INDEX, 32'h0000009F);
        rsp_core_model_inst.push(0, 21'h1FFFFF);
        rd(rsp_pkg::OFS_INDEX, 32'h0000009F);
        rd(rsp_pkg::OFS_TOP_OF_STACK_LOW, 32'h0000003E);
        rd(rsp_pkg::OFS_TOP_OF_STACK_UPPER, 32'h00000000);
        core_reset();
        rd(rsp_pkg::OFS_INDEX, 32'h00000080);
        bus(1'b1, rsp_pkg::OFS_INDEX, 32'h00000005);
        rd(rsp_pkg::OFS_INDEX, 32'h00000005);
    endtask
    task automatic t_overflow();
        bus(1'b1, rsp_pkg::OFS_INDEX, 32'h00000000);
        for (int i = 1; i <= 30; i++) rsp_core_model_inst.push(0, 21'(i));
        rsp_core_model_inst.push(1, 21'h012344);
        #1 chk(overflow_reset_req, 1'b1);
        rd(rsp_pkg::OFS_INDEX, 32'h00000080);
        bus(1'b1, rsp_pkg::OFS_INDEX, 32'h0000009F);
        rd(rsp_pkg::OFS_TOP_OF_STACK_LOW, 32'h00000046);
        rd(rsp_pkg::OFS_TOP_OF_STACK_HIGH, 32'h00000023);
        rd(rsp_pkg::OFS_TOP_OF_STACK_UPPER, 32'h00000001);
        bus(1'b1, rsp_pkg::OFS_TOP_OF_STACK_LOW, 32'h000000C3);
        rd(rsp_pkg::OFS_TOP_OF_STACK_LOW, 32'h000000C3);
        rd(rsp_pkg::OFS_TOP_OF_STACK_HIGH, 32'h00000023);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ceiling well above the roughly 260 cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_b, por_b, hsel, hwrite, htrans} = 6'h00;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        hsize = 3'h2;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        t_reset_values();
        t_push_pop();
        t_underflow();
        t_full_hold();
        t_overflow();
        tally_and_finish();
    end
endmodule // rsp_unit_tb
